// File: ssc_defs.svh
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH

// command addresses
`define SSC_ADDR_LEVEL      8'h11
`define SSC_ADDR_ON_OFF     8'h12
`define SSC_ADDR_PHASE      8'h13
`define SSC_ADDR_AUTO_OFF   8'h14
`define SSC_ADDR_LOOP_SEL   8'h15
`define SSC_ADDR_SLEEP1     8'h16
`define SSC_ADDR_REF_SETUP  8'h17
`define SSC_ADDR_REF_TRIM   8'h18
`define SSC_ADDR_LOOP_DAC   8'h19
`define SSC_ADDR_RSVD_A     8'h1A
`define SSC_ADDR_SAVE       8'h1B
`define SSC_ADDR_PULSE      8'h1C
`define SSC_ADDR_RSVD_B     8'h1D
`define SSC_ADDR_SLEEP2     8'h1E
`define SSC_ADDR_RF2_FREQ   8'h1F
`define SSC_ADDR_DAC_QUERY  8'h25
`define SSC_ADDR_SELF_CAL   8'h47

// storage slots, also the nonvolatile word index
`define SSC_SLOT_LEVEL      4'h0
`define SSC_SLOT_ON_OFF     4'h1
`define SSC_SLOT_PHASE      4'h2
`define SSC_SLOT_AUTO_OFF   4'h3
`define SSC_SLOT_LOOP_SEL   4'h4
`define SSC_SLOT_SLEEP1     4'h5
`define SSC_SLOT_REF_SETUP  4'h6
`define SSC_SLOT_REF_TRIM   4'h7
`define SSC_SLOT_LOOP_DAC   4'h8
`define SSC_SLOT_PULSE      4'h9
`define SSC_SLOT_SLEEP2     4'hA
`define SSC_SLOT_RF2_FREQ   4'hB
`define SSC_SLOT_NONE       4'hF
`define SSC_SLOT_LAST       4'hB
`define SSC_NUM_SLOTS       12

// field positions
`define SSC_SIGN_BIT        15
`define SSC_MAG_MSB         14
`define SSC_DAC_MSB         13
`define SSC_CTRL_BIT        0
`define SSC_REF_LOCK_BIT    0
`define SSC_REF_OUT_BIT     1
`define SSC_REF_PXI_BIT     2
`define SSC_REF_DIRECT_BIT  3
`define SSC_REF_FREQ_LSB    4
`define SSC_REF_FREQ_MSB    5
`define SSC_PULSE_EN_BIT    0
`define SSC_PULSE_SRC_BIT   1
`define SSC_REF_FREQ_10M    2'h0
`define SSC_REF_FREQ_100M   2'h1

// nonvolatile store
`define SSC_NV_DEPTH        16
`define SSC_NV_MARK_IDX     4'hF
`define SSC_NV_MARK         16'hA5C3
`define SSC_CFG_RESET       16'h0000

// readback frame
`define SSC_RB_BYTES        3'h6

`endif

// File: ssc_pkg.sv
package ssc_pkg;

  typedef enum logic [4:0] {
    SSC_ST_IDLE = 5'b00001,
    SSC_ST_CHK  = 5'b00010,
    SSC_ST_LOAD = 5'b00100,
    SSC_ST_SAVE = 5'b01000,
    SSC_ST_MARK = 5'b10000
  } ssc_state_e;

  typedef logic [15:0] ssc_word_t;
  typedef logic [3:0]  ssc_slot_t;
  typedef logic [7:0]  ssc_byte_t;

endpackage : ssc_pkg

// File: ssc_nv_store.sv
`timescale 1ns/100ps
`default_nettype none
`include "ssc_defs.svh"

// contents survive rstn, standing in for the nonvolatile part
module ssc_nv_store
  import ssc_pkg::*;
(
  input  wire logic            ref_clk,
  input  wire logic            we,
  input  wire ssc_pkg::ssc_slot_t waddr,
  input  wire ssc_pkg::ssc_word_t wdata,
  input  wire ssc_pkg::ssc_slot_t raddr,
  output ssc_pkg::ssc_word_t   rdata_q
);

  ssc_word_t mem [0:`SSC_NV_DEPTH-1];

  always_ff @(posedge ref_clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end

endmodule : ssc_nv_store

`default_nettype wire

// File: ssc_config_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "ssc_defs.svh"

module ssc_config_regs
  import ssc_pkg::*;
#(
  parameter bit HW_V3_CAPABLE   = 1'b1,
  parameter bit BACKPLANE_BUILD = 1'b0
)
(
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             cmd_valid,
  input  wire logic             cmd_first,
  input  wire ssc_pkg::ssc_byte_t cmd_byte,
  input  wire logic             rd_req,
  output ssc_pkg::ssc_byte_t    rd_byte,
  output logic                  rd_valid,
  input  wire logic             freq_change,
  input  wire logic             ext_ref_detected,
  output logic                  busy,
  output logic [14:0]           level_mag,
  output logic                  level_neg,
  output logic                  rf_power_on,
  output logic [14:0]           phase_mag,
  output logic                  phase_neg,
  output logic                  relevel,
  output logic                  loop_open,
  output logic                  primary_sleep,
  output logic                  secondary_sleep,
  output logic                  ext_lock_en,
  output logic                  ref_out_100m,
  output logic                  backplane_ref_link,
  output logic                  direct_core_clock,
  output logic                  ext_ref_100m,
  output logic [13:0]           ref_trim,
  output logic [13:0]           loop_dac,
  output logic                  pulse_en,
  output logic                  pulse_trig_backplane,
  output logic [14:0]           rf2_freq_mhz,
  output logic                  self_cal_start
);

  import ssc_pkg::*;

  // address to storage slot; none for command-only addresses
  function automatic ssc_slot_t addr_slot(input ssc_byte_t a);
    case (a)
      `SSC_ADDR_LEVEL:     addr_slot = `SSC_SLOT_LEVEL;
      `SSC_ADDR_ON_OFF:    addr_slot = `SSC_SLOT_ON_OFF;
      `SSC_ADDR_PHASE:     addr_slot = `SSC_SLOT_PHASE;
      `SSC_ADDR_AUTO_OFF:  addr_slot = `SSC_SLOT_AUTO_OFF;
      `SSC_ADDR_LOOP_SEL:  addr_slot = `SSC_SLOT_LOOP_SEL;
      `SSC_ADDR_SLEEP1:    addr_slot = `SSC_SLOT_SLEEP1;
      `SSC_ADDR_REF_SETUP: addr_slot = `SSC_SLOT_REF_SETUP;
      `SSC_ADDR_REF_TRIM:  addr_slot = `SSC_SLOT_REF_TRIM;
      `SSC_ADDR_LOOP_DAC:  addr_slot = `SSC_SLOT_LOOP_DAC;
      `SSC_ADDR_PULSE:     addr_slot = `SSC_SLOT_PULSE;
      `SSC_ADDR_SLEEP2:    addr_slot = `SSC_SLOT_SLEEP2;
      `SSC_ADDR_RF2_FREQ:  addr_slot = `SSC_SLOT_RF2_FREQ;
      default:             addr_slot = `SSC_SLOT_NONE;
    endcase
  endfunction : addr_slot

  // payload length; 0 marks an unknown address, whose frame is dropped
  function automatic logic [1:0] need_bytes(input ssc_byte_t a);
    case (a)
      `SSC_ADDR_LEVEL, `SSC_ADDR_PHASE, `SSC_ADDR_REF_TRIM,
      `SSC_ADDR_LOOP_DAC, `SSC_ADDR_RF2_FREQ:
        need_bytes = 2'd2;
      `SSC_ADDR_ON_OFF, `SSC_ADDR_AUTO_OFF, `SSC_ADDR_LOOP_SEL, `SSC_ADDR_SLEEP1,
      `SSC_ADDR_REF_SETUP, `SSC_ADDR_RSVD_A, `SSC_ADDR_SAVE, `SSC_ADDR_PULSE,
      `SSC_ADDR_RSVD_B, `SSC_ADDR_SLEEP2, `SSC_ADDR_DAC_QUERY, `SSC_ADDR_SELF_CAL:
        need_bytes = 2'd1;
      default:
        need_bytes = 2'd0;
    endcase
  endfunction : need_bytes

  logic       rst_meta_q;
  logic       rst_n_q;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  ssc_state_e st_q;
  ssc_state_e st_d;
  ssc_slot_t  ptr_q;
  logic       chk_seen_q;
  logic       rd_pend_q;
  ssc_slot_t  rd_idx_q;
  ssc_word_t  nv_rdata;
  ssc_word_t  cfg_q [0:`SSC_NUM_SLOTS-1];

  ssc_byte_t  addr_q;
  logic       open_q;
  logic [1:0] cnt_q;
  ssc_byte_t  hold_q;

  // frame parser: first byte is the address, then payload MSB first
  wire        idle       = (st_q == SSC_ST_IDLE);
  wire        take_byte  = cmd_valid && idle;
  wire [1:0]  need       = need_bytes(addr_q);
  wire [1:0]  cnt_next   = cnt_q + 2'd1;
  wire        wr_fire    = take_byte && !cmd_first && open_q && (cnt_next == need);
  wire ssc_word_t wr_value = (need == 2'd2) ? {hold_q, cmd_byte} : {8'h00, cmd_byte};
  wire ssc_slot_t wr_slot  = addr_slot(addr_q);
  wire        save_fire  = wr_fire && (addr_q == `SSC_ADDR_SAVE);
  wire        query_fire = wr_fire && (addr_q == `SSC_ADDR_DAC_QUERY);
  wire        cal_fire   = wr_fire && (addr_q == `SSC_ADDR_SELF_CAL);
  wire        level_fire = wr_fire && (wr_slot == `SSC_SLOT_LEVEL);

  always_ff @(posedge ref_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      addr_q <= 8'h00;
      open_q <= 1'b0;
      cnt_q  <= 2'd0;
      hold_q <= 8'h00;
    end
    else if (!idle)
    begin
      open_q <= 1'b0;
    end
    else if (take_byte && cmd_first)
    begin
      addr_q <= cmd_byte;
      open_q <= (need_bytes(cmd_byte) != 2'd0);
      cnt_q  <= 2'd0;
    end
    else if (take_byte && open_q)
    begin
      hold_q <= cmd_byte;
      cnt_q  <= cnt_next;
      open_q <= !wr_fire;
    end
  end

  // storage: reload from the store beats a host write landing the same cycle
  genvar g;
  generate
    for (g = 0; g < `SSC_NUM_SLOTS; g++)
    begin : g_cfg
      always_ff @(posedge ref_clk or negedge rst_n_q)
      begin
        if (!rst_n_q)
        begin
          cfg_q[g] <= `SSC_CFG_RESET;
        end
        else if (rd_pend_q && (rd_idx_q == 4'(g)))
        begin
          cfg_q[g] <= nv_rdata;
        end
        else if (wr_fire && (wr_slot == 4'(g)))
        begin
          cfg_q[g] <= wr_value;
        end
      end
    end
  endgenerate

  // store sequencer: check the mark after reset, then reload or go idle
  wire        nv_we    = (st_q == SSC_ST_SAVE) || (st_q == SSC_ST_MARK);
  wire ssc_slot_t nv_waddr = (st_q == SSC_ST_MARK) ? `SSC_NV_MARK_IDX : ptr_q;
  wire ssc_word_t nv_wdata = (st_q == SSC_ST_MARK) ? `SSC_NV_MARK : cfg_q[ptr_q];
  wire ssc_slot_t nv_raddr = (st_q == SSC_ST_CHK) ? `SSC_NV_MARK_IDX : ptr_q;
  wire        ptr_last = (ptr_q == `SSC_SLOT_LAST);

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      SSC_ST_IDLE: if (save_fire) st_d = SSC_ST_SAVE;
      // a blank store reads unknown; this form then falls to idle, not a mixed state
      SSC_ST_CHK:  if (chk_seen_q && (nv_rdata == `SSC_NV_MARK)) st_d = SSC_ST_LOAD;
                   else if (chk_seen_q) st_d = SSC_ST_IDLE;
      SSC_ST_LOAD: if (ptr_last) st_d = SSC_ST_IDLE;
      SSC_ST_SAVE: if (ptr_last) st_d = SSC_ST_MARK;
      SSC_ST_MARK: st_d = SSC_ST_IDLE;
      default:     st_d = SSC_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      st_q       <= SSC_ST_CHK;
      ptr_q      <= 4'h0;
      chk_seen_q <= 1'b0;
      rd_pend_q  <= 1'b0;
      rd_idx_q   <= 4'h0;
    end
    else
    begin
      st_q       <= st_d;
      chk_seen_q <= (st_q == SSC_ST_CHK);
      rd_pend_q  <= (st_q == SSC_ST_LOAD);
      rd_idx_q   <= ptr_q;
      if ((st_q == SSC_ST_LOAD) || (st_q == SSC_ST_SAVE))
        ptr_q <= ptr_last ? 4'h0 : ptr_q + 4'h1;
      else
        ptr_q <= 4'h0;
    end
  end

  ssc_nv_store u_store (
    .ref_clk (ref_clk),
    .we      (nv_we),
    .waddr   (nv_waddr),
    .wdata   (nv_wdata),
    .raddr   (nv_raddr),
    .rdata_q (nv_rdata)
  );

  // derived controls
  wire ssc_word_t ref_cfg  = cfg_q[`SSC_SLOT_REF_SETUP];
  wire [1:0]  ref_code     = ref_cfg[`SSC_REF_FREQ_MSB:`SSC_REF_FREQ_LSB];
  wire        code_100m    = HW_V3_CAPABLE && (ref_code == `SSC_REF_FREQ_100M);
  wire        auto_off     = cfg_q[`SSC_SLOT_AUTO_OFF][`SSC_CTRL_BIT];
  wire        sleep1       = cfg_q[`SSC_SLOT_SLEEP1][`SSC_CTRL_BIT];
  // primary standby (sleep1) overrides the on bit: the channel circuitry is powered down
  wire        power_d      = cfg_q[`SSC_SLOT_ON_OFF][`SSC_CTRL_BIT] && !sleep1;
  wire        relevel_d    = level_fire || (freq_change && !auto_off);

  logic        relevel_q, cal_q, power_q, lock_q, direct_q, link_q, e100_q, busy_q;
  logic [47:0] rb_q;
  logic [2:0]  rb_cnt_q;
  ssc_byte_t   rd_byte_q;
  logic        rd_valid_q;

  always_ff @(posedge ref_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      relevel_q <= 1'b0;
      cal_q     <= 1'b0;
      power_q   <= 1'b0;
      lock_q    <= 1'b0;
      direct_q  <= 1'b0;
      link_q    <= 1'b0;
      e100_q    <= 1'b0;
      busy_q    <= 1'b1;
    end
    else
    begin
      relevel_q <= relevel_d;
      cal_q     <= cal_fire;
      power_q   <= power_d;
      lock_q    <= ref_cfg[`SSC_REF_LOCK_BIT] && ext_ref_detected;
      direct_q  <= ref_cfg[`SSC_REF_DIRECT_BIT] && code_100m;
      link_q    <= BACKPLANE_BUILD && ref_cfg[`SSC_REF_PXI_BIT];
      e100_q    <= code_100m;
      // held through the last reload so no stale word shows once busy drops
      busy_q    <= (st_d != SSC_ST_IDLE) || (st_q == SSC_ST_LOAD);
    end
  end

  // dac readback: six bytes MSB first, value in the first two, rest zero
  always_ff @(posedge ref_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rb_q       <= 48'h0;
      rb_cnt_q   <= 3'h0;
      rd_byte_q  <= 8'h00;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= 1'b0;
      if (query_fire)
      begin
        rb_q     <= {2'b00, cfg_q[`SSC_SLOT_LOOP_DAC][`SSC_DAC_MSB:0], 32'h0};
        rb_cnt_q <= `SSC_RB_BYTES;
      end
      else if (rd_req && (rb_cnt_q != 3'h0))
      begin
        rd_byte_q  <= rb_q[47:40];
        rd_valid_q <= 1'b1;
        rb_q       <= {rb_q[39:0], 8'h00};
        rb_cnt_q   <= rb_cnt_q - 3'h1;
      end
    end
  end

  // field outputs are plain slices of stored flops
  assign level_mag            = cfg_q[`SSC_SLOT_LEVEL][`SSC_MAG_MSB:0];
  assign level_neg            = cfg_q[`SSC_SLOT_LEVEL][`SSC_SIGN_BIT];
  assign phase_mag            = cfg_q[`SSC_SLOT_PHASE][`SSC_MAG_MSB:0];
  assign phase_neg            = cfg_q[`SSC_SLOT_PHASE][`SSC_SIGN_BIT];
  assign loop_open            = cfg_q[`SSC_SLOT_LOOP_SEL][`SSC_CTRL_BIT];
  assign primary_sleep        = sleep1;
  assign secondary_sleep      = cfg_q[`SSC_SLOT_SLEEP2][`SSC_CTRL_BIT];
  assign ref_out_100m         = ref_cfg[`SSC_REF_OUT_BIT];
  assign ref_trim             = cfg_q[`SSC_SLOT_REF_TRIM][`SSC_DAC_MSB:0];
  assign loop_dac             = cfg_q[`SSC_SLOT_LOOP_DAC][`SSC_DAC_MSB:0];
  assign pulse_en             = cfg_q[`SSC_SLOT_PULSE][`SSC_PULSE_EN_BIT];
  assign pulse_trig_backplane = cfg_q[`SSC_SLOT_PULSE][`SSC_PULSE_SRC_BIT];
  // range is the host's duty; stored as written
  assign rf2_freq_mhz         = cfg_q[`SSC_SLOT_RF2_FREQ][`SSC_MAG_MSB:0];
  assign rf_power_on          = power_q;
  assign relevel              = relevel_q;
  assign self_cal_start       = cal_q;
  assign ext_lock_en          = lock_q;
  assign direct_core_clock    = direct_q;
  assign backplane_ref_link   = link_q;
  assign ext_ref_100m         = e100_q;
  assign busy                 = busy_q;
  assign rd_byte              = rd_byte_q;
  assign rd_valid             = rd_valid_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_q);

  sequence s_save_cmd;
    save_fire;
  endsequence

  sequence s_save_done;
    (st_q == SSC_ST_MARK) ##1 (st_q == SSC_ST_IDLE);
  endsequence

  a_level_sign_store: assert property (
    level_fire |=> (level_neg == $past(hold_q[7])) && (level_mag[7:0] == $past(cmd_byte)))
    else $error("level field not taken from written word");

  a_power_on_write: assert property (
    (wr_fire && wr_slot == `SSC_SLOT_ON_OFF && cmd_byte[0] && !sleep1
      && !(rd_pend_q)) |-> ##2 rf_power_on)
    else $error("output power not switched on after write");

  a_phase_sign_store: assert property (
    (wr_fire && wr_slot == `SSC_SLOT_PHASE) |=> (phase_neg == $past(hold_q[7])))
    else $error("phase sign not taken from bit 15");

  a_relevel_auto: assert property (
    (freq_change && !auto_off) |=> relevel)
    else $error("no relevel on frequency change");

  a_relevel_held: assert property (
    (freq_change && auto_off && !level_fire) |=> !relevel)
    else $error("relevel while auto leveling disabled");

  a_lock_detect: assert property (
    !ext_ref_detected |=> !ext_lock_en)
    else $error("external lock without detected reference");

  a_direct_clock: assert property (
    direct_core_clock |-> $past(ref_code == `SSC_REF_FREQ_100M && HW_V3_CAPABLE))
    else $error("direct clocking without 100 MHz reference code");

  a_save_sequence: assert property (
    s_save_cmd |-> ##13 s_save_done)
    else $error("save sequence did not finish on time");

  a_self_cal_pulse: assert property (
    cal_fire |=> self_cal_start ##1 !self_cal_start)
    else $error("self calibration start not a single pulse");

  a_dac_readback: assert property (
    query_fire |=> (rb_cnt_q == `SSC_RB_BYTES) && (rb_q[45:32] == $past(loop_dac)))
    else $error("dac readback not loaded");

endmodule : ssc_config_regs

`default_nettype wire

// File: ssc_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// command-link host: one byte per cycle, launched just after the edge
module ssc_host_model
(
  input  wire logic          ref_clk,
  output ssc_pkg::ssc_byte_t cmd_byte,
  output logic               cmd_valid,
  output logic               cmd_first,
  output logic               rd_req
);
  import ssc_pkg::*;

  initial
  begin
    cmd_byte  = 8'h00;
    cmd_valid = 1'b0;
    cmd_first = 1'b0;
    rd_req    = 1'b0;
  end

  task automatic send(input ssc_byte_t b, input logic first);
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_first = first;
    cmd_byte  = b;
  endtask : send

  // caller keeps payload in range and unused bits zero
  task automatic wr(input ssc_byte_t a, input logic two, input ssc_word_t d);
    send(a, 1'b1);
    if (two)
      send(d[15:8], 1'b0);
    send(d[7:0], 1'b0);
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    cmd_first = 1'b0;
    // released lines never show the last byte
    cmd_byte  = ~cmd_byte;
  endtask : wr

  task automatic pop();
    @(posedge ref_clk);
    #1;
    rd_req = 1'b1;
    @(posedge ref_clk);
    #1;
    rd_req = 1'b0;
  endtask : pop

endmodule : ssc_host_model
`default_nettype wire

// File: ssc_config_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none

module ssc_config_regs_tb;
  import ssc_pkg::*;
  logic      ref_clk, rstn, freq_change, ext_ref_detected;
  wire ssc_byte_t cmd_byte, rd_byte;
  wire logic cmd_valid, cmd_first, rd_req, rd_valid, busy, level_neg, rf_power_on;
  wire logic phase_neg, relevel, loop_open, primary_sleep, secondary_sleep, ext_lock_en;
  wire logic ref_out_100m, backplane_ref_link, direct_core_clock, ext_ref_100m;
  wire logic pulse_en, pulse_trig_backplane, self_cal_start;
  wire logic [14:0] level_mag, phase_mag, rf2_freq_mhz;
  wire logic [13:0] ref_trim, loop_dac;
  int        n_mismatch, checked;
  ssc_byte_t exp_q[$];
  ssc_word_t rnd, w, lv;
  logic [5:0] d;
  logic       c1;

  ssc_config_regs uut (.ref_clk, .rstn, .cmd_valid, .cmd_first, .cmd_byte, .rd_req,
    .rd_byte, .rd_valid, .freq_change, .ext_ref_detected, .busy, .level_mag, .level_neg,
    .rf_power_on, .phase_mag, .phase_neg, .relevel, .loop_open, .primary_sleep,
    .secondary_sleep, .ext_lock_en, .ref_out_100m, .backplane_ref_link,
    .direct_core_clock, .ext_ref_100m, .ref_trim, .loop_dac, .pulse_en,
    .pulse_trig_backplane, .rf2_freq_mhz, .self_cal_start);

  ssc_host_model host (.ref_clk, .cmd_byte, .cmd_valid, .cmd_first, .rd_req);

  always #2 ref_clk = ~ref_clk;

  function automatic ssc_word_t lfsr(input ssc_word_t s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic chk(input ssc_word_t seen, input ssc_word_t exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("counts: checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask : step

  task automatic wait_idle();
    for (int i = 0; i < 200 && busy !== 1'b0; i++)
      step();
    if (busy !== 1'b0)
    begin
      n_mismatch++;
      summarize();
    end
  endtask : wait_idle

  // readback bytes are sampled mid-cycle, where settled; an empty queue means an unasked byte
  always @(negedge ref_clk)
    if (rd_valid === 1'b1)
      chk({8'h00, rd_byte}, exp_q.size() > 0 ? {8'h00, exp_q.pop_front()} : 16'hFFFF);

  initial
  begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    freq_change = 1'b0;
    ext_ref_detected = 1'b0;
    n_mismatch = 0;
    checked = 0;
    rnd = 16'h000A;
    repeat (6) @(posedge ref_clk);
    #1;
    chk({busy, level_mag}, 16'h8000);
    rstn = 1'b1;
    wait_idle();
    $display("test reset done");

    repeat (4)
    begin
      rnd = lfsr(rnd);
      lv = rnd;
      host.wr(8'h11, 1'b1, lv);
      chk({level_neg, level_mag}, lv);
      chk(relevel, 16'h0001);
      step();
      chk(relevel, 16'h0000);
      rnd = lfsr(rnd);
      host.wr(8'h13, 1'b1, rnd);
      chk({phase_neg, phase_mag}, rnd);
    end
    $display("test level and phase done");

    host.wr(8'h16, 1'b0, 16'h0000);
    host.wr(8'h12, 1'b0, 16'h0001);
    step();
    chk(rf_power_on, 16'h0001);
    host.wr(8'h12, 1'b0, 16'h0000);
    step();
    chk(rf_power_on, 16'h0000);
    host.wr(8'h12, 1'b0, 16'h0001);
    host.wr(8'h16, 1'b0, 16'h0001);
    step();
    chk({primary_sleep, rf_power_on}, 16'h0002);
    host.wr(8'h1E, 1'b0, 16'h0001);
    chk(secondary_sleep, 16'h0001);
    host.wr(8'h1E, 1'b0, 16'h0000);
    chk(secondary_sleep, 16'h0000);
    $display("test power and standby done");

    for (int v = 0; v < 2; v++)
    begin
      host.wr(8'h14, 1'b0, 16'(v));
      host.wr(8'h15, 1'b0, 16'(v));
      chk(loop_open, 16'(v));
      step();
      freq_change = 1'b1;
      step();
      freq_change = 1'b0;
      chk(relevel, 16'(v == 0));
    end
    $display("test leveling done");

    for (int i = 0; i < 64; i++)
    begin
      d = i[5:0];
      ext_ref_detected = d[2] ^ d[4];
      host.wr(8'h17, 1'b0, {10'h000, d});
      step();
      c1 = (d[5:4] == 2'h1);
      chk({ext_lock_en, ref_out_100m}, {ext_ref_detected & d[0], d[1]});
      chk(backplane_ref_link, 16'h0000);
      chk({direct_core_clock, ext_ref_100m}, {d[3] & c1, c1});
    end
    $display("test reference done");

    rnd = lfsr(rnd);
    host.wr(8'h18, 1'b1, rnd & 16'h3FFF);
    chk(ref_trim, rnd & 16'h3FFF);
    rnd = lfsr(rnd);
    w = rnd & 16'h3FFF;
    host.wr(8'h19, 1'b1, w);
    chk(loop_dac, w);
    host.wr(8'h25, 1'b0, 16'h0000);
    for (int k = 0; k < 6; k++)
      exp_q.push_back(k == 0 ? {2'b00, w[13:8]} : k == 1 ? w[7:0] : 8'h00);
    // the seventh pop finds nothing left and must stay silent
    repeat (7) host.pop();
    step();
    step();
    chk(16'(exp_q.size()), 16'h0000);
    $display("test dac readback done");

    for (int m = 0; m < 4; m++)
    begin
      host.wr(8'h1C, 1'b0, 16'(m));
      chk({pulse_trig_backplane, pulse_en}, 16'(m));
    end
    host.wr(8'h1F, 1'b1, 16'h0BB8);
    chk(rf2_freq_mhz, 16'h0BB8);
    host.wr(8'h1F, 1'b1, 16'h0019);
    chk(rf2_freq_mhz, 16'h0019);
    host.wr(8'h1A, 1'b0, 16'h0000);
    host.wr(8'h1D, 1'b0, 16'h0000);
    chk({level_neg, level_mag}, lv);
    host.wr(8'h47, 1'b0, 16'h0000);
    chk(self_cal_start, 16'h0001);
    step();
    chk(self_cal_start, 16'h0000);
    $display("test pulse, tone, calibrate done");

    host.wr(8'h1B, 1'b0, 16'h0000);
    step();
    chk(busy, 16'h0001);
    wait_idle();
    rstn = 1'b0;
    step();
    chk({busy, level_mag}, 16'h8000);
    rstn = 1'b1;
    step();
    wait_idle();
    // stored state comes back as the power-on default
    chk({level_neg, level_mag}, lv);
    chk(loop_dac, w);
    chk(rf2_freq_mhz, 16'h0019);
    $display("test save and reload done");
    summarize();
  end

endmodule : ssc_config_regs_tb
`default_nettype wire
